// ===== hw/ccap_regs.sv
// Purpose: APB read-only identify tail fields plus consistency status
// Assumes: admin support and firmware attribute inputs come from same clock
// Notes: answers one cycle after setup; capture refreshes status
`timescale 1ns/1ps
`include "ccap_params.svh"
module ccap_regs
  import ccap_pkg::*;
#(
  parameter logic APST_SUPPORTED = 1'b1,
  parameter logic [15:0] WARN_TEMP = `CCAP_WARN_RECOMMENDED,
  parameter logic [15:0] CRIT_TEMP = 16'h0170,
  parameter logic [15:0] FW_ACT_TIME = 16'h000a,
  parameter logic [31:0] HMB_PREF = 32'h0000_0000,
  parameter logic [31:0] HMB_MIN = 32'h0000_0000,
  parameter logic [127:0] TOTAL_CAP = 128'h0,
  parameter logic [127:0] UNALLOC_CAP = 128'h0,
  parameter logic [15:0] SPEC_REV = 16'h0102
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [15:0] optional_admin_cmd_support_in,
  input wire logic [7:0] firmware_update_attrs_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic config_ok_out,
  output logic hmb_supported_out,
  output logic apst_supported_out
);

  ccap_state_t st;
  ccap_state_t next_st;

  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic done;
  logic wr_ctrl;
  logic capture;
  logic hit;
  logic hit_total;
  logic hit_unalloc;
  logic [31:0] rd;
  logic [31:0] total_word;
  logic [31:0] unalloc_word;
  logic warn_nz;
  logic crit_nz;
  logic rev_ok;
  logic hmb_order;
  logic fw_ok;
  logic cap_ok;
  logic [`CCAP_ST_W-1:0] new_status;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign idx = paddr_in[11:2];
  assign aligned = (paddr_in[1:0] == 2'h0);
  assign setup = psel_in & ~penable_in;
  assign done = st.pready & psel_in & penable_in;
  assign hit_total = (idx[9:2] == `CCAP_IDX_TOTAL >> 2);
  assign hit_unalloc = (idx[9:2] == `CCAP_IDX_UNALLOC >> 2);
  // control write takes effect only on the completing edge
  assign wr_ctrl = done & pwrite_in & aligned & pstrb_in[0] &
                   (idx == `CCAP_IDX_CTRL);

  ccap_field_word #(
    .FIELD_W(128)
  ) u_total (
    .field_in(TOTAL_CAP),
    .sel_in(idx[1:0]),
    .word_out(total_word)
  );

  ccap_field_word #(
    .FIELD_W(128)
  ) u_unalloc (
    .field_in(UNALLOC_CAP),
    .sel_in(idx[1:0]),
    .word_out(unalloc_word)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd = 32'h0;
    hit = 1'b1;
    if (idx == `CCAP_IDX_APST) begin
      rd = {31'h0, APST_SUPPORTED};
    end else if (idx == `CCAP_IDX_WARN) begin
      rd = {16'h0, WARN_TEMP};
    end else if (idx == `CCAP_IDX_CRIT) begin
      rd = {16'h0, CRIT_TEMP};
    end else if (idx == `CCAP_IDX_FWACT) begin
      rd = {16'h0, FW_ACT_TIME};
    end else if (idx == `CCAP_IDX_HMPREF) begin
      rd = HMB_PREF;
    end else if (idx == `CCAP_IDX_HOST_BUFFER_MIN_SIZE) begin
      rd = HMB_MIN;
    end else if (hit_total) begin
      rd = total_word;
    end else if (hit_unalloc) begin
      rd = unalloc_word;
    end else if (idx == `CCAP_IDX_CTRL) begin
      rd = {30'h0, st.auto_track, 1'b0};
    end else if (idx == `CCAP_IDX_STATUS) begin
      rd = {{(32-`CCAP_ST_W){1'b0}}, st.status};
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // consistency checks
  // ----------------------------------------------------------------
  assign warn_nz = (WARN_TEMP != 16'h0);
  assign crit_nz = (CRIT_TEMP != 16'h0);
  assign rev_ok = (SPEC_REV < `CCAP_REV_MIN) | (warn_nz & crit_nz);
  assign hmb_order = (HMB_PREF == 32'h0) | (HMB_PREF >= HMB_MIN);
  assign fw_ok = ~firmware_update_attrs_in[`CCAP_FIRMWARE_UPDATE_ATTRS_NORST_BIT] |
                 (FW_ACT_TIME != 16'h0);
  assign cap_ok = ~optional_admin_cmd_support_in[`CCAP_OPTIONAL_ADMIN_CMD_SUPPORT_NS_BIT] |
                  (TOTAL_CAP != 128'h0);

  always_comb begin
    new_status = '0;
    new_status[`CCAP_ST_WARN_NZ] = warn_nz;
    new_status[`CCAP_ST_CRIT_NZ] = crit_nz;
    new_status[`CCAP_ST_REV_OK] = rev_ok;
    new_status[`CCAP_ST_HMB_ORDER] = hmb_order;
    new_status[`CCAP_ST_FW_OK] = fw_ok;
    new_status[`CCAP_ST_CAP_OK] = cap_ok;
    new_status[`CCAP_ST_HMB_SUP] = (HMB_PREF != 32'h0);
    new_status[`CCAP_ST_APST_SUP] = APST_SUPPORTED;
    new_status[`CCAP_ST_CFG_OK] = rev_ok & hmb_order & fw_ok & cap_ok;
  end

  // first capture follows reset release, so no port reaches the reset
  assign capture = ~st.captured | st.auto_track |
                   (wr_ctrl & pwdata_in[`CCAP_CTRL_CAPTURE]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pready = setup & ~st.pready;
    next_st.pslverr = 1'b0;
    if (setup & ~st.pready) begin
      next_st.pslverr = ~(hit & aligned);
      next_st.prdata = (pwrite_in | ~(hit & aligned)) ? 32'h0 : rd;
    end
    if (wr_ctrl) begin
      next_st.auto_track = pwdata_in[`CCAP_CTRL_AUTO];
    end
    if (capture) begin
      next_st.captured = 1'b1;
      next_st.status = new_status;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign config_ok_out = st.status[`CCAP_ST_CFG_OK];
  assign hmb_supported_out = st.status[`CCAP_ST_HMB_SUP];
  assign apst_supported_out = st.status[`CCAP_ST_APST_SUP];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_apst_read_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_APST)
    |-> prdata_out == {31'h0, APST_SUPPORTED})
    else $error("autonomous transition byte read wrong");

  chk_warn_read_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && !pwrite_in && !pready_out &&
     paddr_in == {`CCAP_IDX_WARN, 2'h0})
    |=> pready_out && prdata_out == {16'h0, WARN_TEMP})
    else $error("warning threshold read wrong");

  chk_rev_thresholds: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_STATUS)
    |-> prdata_out[`CCAP_ST_REV_OK] == (SPEC_REV < `CCAP_REV_MIN ||
        (WARN_TEMP != 16'h0 && CRIT_TEMP != 16'h0)))
    else $error("revision threshold status wrong");

  chk_crit_read_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_CRIT)
    |-> prdata_out[31:16] == 16'h0 && prdata_out[15:0] == CRIT_TEMP)
    else $error("critical threshold read wrong");

  chk_fw_time_valid: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rst_n_in && capture |=>
      st.status[`CCAP_ST_FW_OK] ==
      (!$past(firmware_update_attrs_in[`CCAP_FIRMWARE_UPDATE_ATTRS_NORST_BIT]) ||
       FW_ACT_TIME != 16'h0))
    else $error("activation time check wrong");

  chk_hmb_support: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(st.captured) |->
      hmb_supported_out == (HMB_PREF != 32'h0) &&
      st.status[`CCAP_ST_HMB_ORDER] ==
      (HMB_PREF == 32'h0 || HMB_PREF >= HMB_MIN))
    else $error("host buffer support wrong");

  chk_host_buffer_min_size_read_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_HOST_BUFFER_MIN_SIZE)
    |-> prdata_out == HMB_MIN)
    else $error("minimum buffer size read wrong");

  chk_capacity_read: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out && hit_total)
    |-> prdata_out == TOTAL_CAP[idx[1:0]*32 +: 32])
    else $error("total capacity read wrong");

  chk_ns_capacity: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rst_n_in && capture |=>
      st.status[`CCAP_ST_CAP_OK] ==
      (!$past(optional_admin_cmd_support_in[`CCAP_OPTIONAL_ADMIN_CMD_SUPPORT_NS_BIT]) ||
       TOTAL_CAP != 128'h0))
    else $error("capacity check wrong");

  chk_ro_write_ignored: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (done && pwrite_in && idx != `CCAP_IDX_CTRL)
    |=> $stable(st.auto_track) && prdata_out == 32'h0 ##0 !pready_out)
    else $error("write to read-only field had effect");

  chk_apb_ready_timing: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && !pready_out)
    |=> pready_out ##1 !pready_out)
    else $error("apb answer timing wrong");

  chk_fwact_read_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_FWACT)
    |-> prdata_out == {16'h0, FW_ACT_TIME})
    else $error("activation time read wrong");

  chk_hmpref_read_value: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_HMPREF)
    |-> prdata_out == HMB_PREF)
    else $error("preferred buffer size read wrong");

  chk_unalloc_read: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out && hit_unalloc)
    |-> prdata_out == UNALLOC_CAP[idx[1:0]*32 +: 32])
    else $error("unallocated capacity read wrong");

  chk_error_response: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && !pready_out && !(hit && aligned))
    |=> pready_out && pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access answered wrong");

  chk_write_data_zero: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && pwrite_in && !pready_out)
    |=> pready_out && prdata_out == 32'h0)
    else $error("write returned read data");

  chk_ctrl_strobe_mask: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (done && pwrite_in && idx == `CCAP_IDX_CTRL && !pstrb_in[0])
    |=> $stable(st.auto_track))
    else $error("masked control write had effect");

  chk_warn_nz_status: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_STATUS)
    |-> prdata_out[`CCAP_ST_WARN_NZ] == (WARN_TEMP != 16'h0))
    else $error("warning nonzero status wrong");

  chk_crit_nz_status: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_STATUS)
    |-> prdata_out[`CCAP_ST_CRIT_NZ] == (CRIT_TEMP != 16'h0))
    else $error("critical nonzero status wrong");

  chk_hmb_sup_status: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && !pwrite_in && !pslverr_out &&
     idx == `CCAP_IDX_STATUS)
    |-> prdata_out[`CCAP_ST_HMB_SUP] == (HMB_PREF != 32'h0))
    else $error("host buffer status read wrong");

  chk_apst_status: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    st.captured |-> apst_supported_out == APST_SUPPORTED)
    else $error("autonomous transition support wrong");

endmodule // ccap_regs

// ===== hw/ccap_params.svh
// Purpose: offsets, field positions and limits of the identify tail block
// Assumes: register index = printed byte offset, byte address = 4 * index
// Notes: 128-bit capacity fields span four consecutive indices, low word first
`ifndef CCAP_PARAMS_SVH
`define CCAP_PARAMS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CCAP_IDX_APST 10'h109
`define CCAP_IDX_WARN 10'h10a
`define CCAP_IDX_CRIT 10'h10c
`define CCAP_IDX_FWACT 10'h10e
`define CCAP_IDX_HMPREF 10'h110
`define CCAP_IDX_HOST_BUFFER_MIN_SIZE 10'h114
`define CCAP_IDX_TOTAL 10'h118
`define CCAP_IDX_UNALLOC 10'h128
`define CCAP_IDX_CTRL 10'h140
`define CCAP_IDX_STATUS 10'h141

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCAP_CTRL_CAPTURE 0
`define CCAP_CTRL_AUTO 1
`define CCAP_ST_WARN_NZ 0
`define CCAP_ST_CRIT_NZ 1
`define CCAP_ST_REV_OK 2
`define CCAP_ST_HMB_ORDER 3
`define CCAP_ST_FW_OK 4
`define CCAP_ST_CAP_OK 5
`define CCAP_ST_HMB_SUP 6
`define CCAP_ST_APST_SUP 7
`define CCAP_ST_CFG_OK 8
`define CCAP_ST_W 9
`define CCAP_OPTIONAL_ADMIN_CMD_SUPPORT_NS_BIT 3
`define CCAP_FIRMWARE_UPDATE_ATTRS_NORST_BIT 4

// ----------------------------------------------------------------
// limits and defaults
// ----------------------------------------------------------------
`define CCAP_REV_MIN 16'h0102
`define CCAP_WARN_RECOMMENDED 16'h0157

`endif

// ===== hw/ccap_pkg.sv
// Purpose: types of the identify tail block
// Assumes: ccap_params.svh gives the status width
// Notes: one packed struct carries all state of the main module
`include "ccap_params.svh"
package ccap_pkg;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic captured;
    logic auto_track;
    logic [`CCAP_ST_W-1:0] status;
  } ccap_state_t;

endpackage

// ===== hw/ccap_field_word.sv
// Purpose: picks one 32-bit word out of a wide field
// Assumes: field width is a multiple of 32, up to four words
// Notes: word 0 is the least significant
`timescale 1ns/1ps
module ccap_field_word #(
  parameter int FIELD_W = 128
) (
  input wire logic [FIELD_W-1:0] field_in,
  input wire logic [1:0] sel_in,
  output logic [31:0] word_out
);

  localparam int NWORDS = FIELD_W / 32;

  logic [31:0] words [4];

  // ----------------------------------------------------------------
  // word split
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (i < NWORDS) begin
        words[i] = field_in[i*32 +: 32];
      end else begin
        words[i] = 32'h0;
      end
    end
    word_out = words[sel_in];
  end

endmodule // ccap_field_word

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the identify tail register block
// Assumes: bus task polls pready and checks that it comes with no wait cycle
// Notes: activation time, buffer and capacity values are chosen here and handed to the block as parameters
`timescale 1ns/1ps
`include "ccap_params.svh"
module tb_top;
  // ----------------------------------------------------------------
  // field values and signals
  // ----------------------------------------------------------------
  localparam logic [31:0] HP = 32'h0000_0040;
  localparam logic [31:0] HM = 32'h0000_0010;
  localparam logic [127:0] TC = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  localparam logic [127:0] UC = 128'h0000_0001_0000_0002_0000_0003_0000_0004;
  localparam logic [11:0] CTRL = {`CCAP_IDX_CTRL, 2'b00};
  localparam logic [11:0] STAT = {`CCAP_IDX_STATUS, 2'b00};
  typedef struct packed {
    logic [9:0] idx;
    logic [1:0] lo;
    logic [31:0] data;
    logic err;
  } ccap_row_t;
  ccap_row_t rows [18];
  logic clk_sys_in, rst_n_in, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] optional_admin_cmd_support;
  logic [7:0] firmware_update_attrs;
  logic pready, pslverr, config_ok, hmb_sup, apst_sup, er;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  ccap_regs #(
    .FW_ACT_TIME(16'h0000),
    .HMB_PREF(HP),
    .HMB_MIN(HM),
    .TOTAL_CAP(TC),
    .UNALLOC_CAP(UC)
  ) DUT (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .pstrb_in(pstrb),
    .optional_admin_cmd_support_in(optional_admin_cmd_support),
    .firmware_update_attrs_in(firmware_update_attrs),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .config_ok_out(config_ok),
    .hmb_supported_out(hmb_sup),
    .apst_supported_out(apst_sup)
  );

  // ----------------------------------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------------------------------
  initial clk_sys_in = 1'b0;
  always #50 clk_sys_in = ~clk_sys_in;

  // ceiling well above the some 96 cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until pready is sampled high at an edge, released there
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rdv, output logic erv);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    // values read right after the edge are those the edge sampled
    while (pready !== 1'b1) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk("pready wait", n, 32'h0);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    optional_admin_cmd_support = 16'h0000;
    firmware_update_attrs = 8'h00;
    rows = '{
      '{`CCAP_IDX_APST, 2'b00, 32'h1, 1'b0},
      '{`CCAP_IDX_WARN, 2'b00, 32'h157, 1'b0},
      '{`CCAP_IDX_CRIT, 2'b00, 32'h170, 1'b0},
      '{`CCAP_IDX_FWACT, 2'b00, 32'h0, 1'b0},
      '{`CCAP_IDX_HMPREF, 2'b00, HP, 1'b0},
      '{`CCAP_IDX_HOST_BUFFER_MIN_SIZE, 2'b00, HM, 1'b0},
      '{`CCAP_IDX_TOTAL, 2'b00, TC[31:0], 1'b0},
      '{`CCAP_IDX_TOTAL + 10'h1, 2'b00, TC[63:32], 1'b0},
      '{`CCAP_IDX_TOTAL + 10'h2, 2'b00, TC[95:64], 1'b0},
      '{`CCAP_IDX_TOTAL + 10'h3, 2'b00, TC[127:96], 1'b0},
      '{`CCAP_IDX_UNALLOC, 2'b00, UC[31:0], 1'b0},
      '{`CCAP_IDX_UNALLOC + 10'h1, 2'b00, UC[63:32], 1'b0},
      '{`CCAP_IDX_UNALLOC + 10'h2, 2'b00, UC[95:64], 1'b0},
      '{`CCAP_IDX_UNALLOC + 10'h3, 2'b00, UC[127:96], 1'b0},
      '{10'h3ff, 2'b00, 32'h0, 1'b1},
      '{`CCAP_IDX_WARN, 2'b10, 32'h0, 1'b1},
      '{`CCAP_IDX_STATUS, 2'b00, 32'h1ff, 1'b0},
      '{`CCAP_IDX_APST, 2'b00, 32'h1, 1'b0}
    };
    repeat (9) @(posedge clk_sys_in);
    #1;
    chk("reset pready", {31'h0, pready}, 32'h0);
    chk("reset config", {31'h0, config_ok}, 32'h0);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, {rows[i].idx, rows[i].lo}, 32'h0, 4'hf, rd, er);
      chk("read data", rd, rows[i].data);
      chk("slave error", {31'h0, er}, {31'h0, rows[i].err});
    end
    // writes to a field leave it unchanged
    apb(1'b1, {`CCAP_IDX_WARN, 2'b00}, 32'hffff_ffff, 4'hf, rd, er);
    chk("field write error", {31'h0, er}, 32'h0);
    apb(1'b0, {`CCAP_IDX_WARN, 2'b00}, 32'h0, 4'hf, rd, er);
    chk("warn after write", rd, 32'h157);
    apb(1'b1, 12'hffc, 32'h1, 4'hf, rd, er);
    chk("unmapped write error", {31'h0, er}, 32'h1);
    // reset-free activation with an undefined time, capture masked first
    firmware_update_attrs <= 8'h10;
    apb(1'b1, CTRL, 32'h1, 4'he, rd, er);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("config kept", {31'h0, config_ok}, 32'h1);
    apb(1'b1, CTRL, 32'h1, 4'h1, rd, er);
    apb(1'b0, STAT, 32'h0, 4'hf, rd, er);
    chk("status fw", rd, 32'h0ef);
    chk("config fw", {31'h0, config_ok}, 32'h0);
    // tracking follows the inputs without a capture write
    firmware_update_attrs <= 8'h00;
    optional_admin_cmd_support <= 16'h0008;
    apb(1'b1, CTRL, 32'h2, 4'h1, rd, er);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("config tracked", {31'h0, config_ok}, 32'h1);
    chk("hmb supported", {31'h0, hmb_sup}, 32'h1);
    chk("apst supported", {31'h0, apst_sup}, 32'h1);
    // reset in mid-run clears tracking and recaptures at once
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("mid reset pready", {31'h0, pready}, 32'h0);
    chk("mid reset config", {31'h0, config_ok}, 32'h0);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("config recaptured", {31'h0, config_ok}, 32'h1);
    apb(1'b0, CTRL, 32'h0, 4'hf, rd, er);
    chk("ctrl after reset", rd, 32'h0);
    stop_test();
  end
endmodule // tb_top
